// *** logic/adccfg_pkg.sv ***
// constants, field layouts and state types of the identity and global configuration registers
// ---------------------------------------------------------------------------
// Operation
// R1 - The identity register is read-only, its top three bits give a silicon revision and bit 4 always reads one.
// R2 - Bits 3 to 2 of the identity register return a fixed family code.
// R3 - The two low identity bits give the channel count as 00 for four, 01 for six and 10 for eight channels.
// R4 - Bit 6 of the rate and clock register picks daisy-chain at zero and multiple readback at one.
// R5 - Bit 5 of the rate and clock register drives the oscillator onto the clock pin only while the clock-select pin is high.
// R6 - The modulator runs at half the master clock and the output rate is it divided by 64 doubling per code up to 4096.
// R7 - The host never programs the reserved rate code 111.
// R8 - Bit 4 of the test register picks external test signals at zero and internal ones at one.
// R9 - Bit 2 of the test register picks single or double internal test amplitude.
// R10 - The test frequency field pulses at master clock over 2^21 for 00, over 2^20 for 01, dc for 11, with 10 unused.
// R11 - The rate and clock register sits at 01h and resets to 96h.
// R12 - The test register sits at 02h and resets to C0h.
// R13 - The reference and bias register sits at 03h, resets to 60h and selects reference source and bias operation.
// R14 - The host writes every reserved bit with its reset value.
// ---------------------------------------------------------------------------
package adccfg_pkg;

	// ---------------------------------------------------------------------------
	// serial frame
	// ---------------------------------------------------------------------------
	localparam int           ADDR_W             = 7;
	localparam int           DATA_W             = 8;
	localparam logic [4:0]   BITCNT_CMD_LAST    = 5'h07;
	localparam logic [4:0]   BITCNT_SHIFT_FIRST = 5'h08;
	localparam logic [4:0]   BITCNT_DATA_LAST   = 5'h0f;
	localparam logic [4:0]   BITCNT_FRAME       = 5'h10;

	// ---------------------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------------------
	localparam logic [6:0]   ADDR_IDENTITY      = 7'h00;
	localparam logic [6:0]   ADDR_RATE_CLOCK    = 7'h01;
	localparam logic [6:0]   ADDR_TEST          = 7'h02;
	localparam logic [6:0]   ADDR_REF_BIAS      = 7'h03;
	localparam logic [7:0]   READ_UNMAPPED      = 8'h00;

	// ---------------------------------------------------------------------------
	// field codes
	// ---------------------------------------------------------------------------
	localparam logic [2:0]   RATE_CODE_RESERVED = 3'h7;
	localparam logic [2:0]   RATE_CODE_SLOWEST  = 3'h6;
	localparam logic [1:0]   TEST_FREQ_SLOW     = 2'h0;
	localparam logic [1:0]   TEST_FREQ_FAST     = 2'h1;
	localparam logic [1:0]   TEST_FREQ_UNUSED   = 2'h2;
	localparam logic [1:0]   TEST_FREQ_DC       = 2'h3;
	localparam logic [1:0]   CH_CODE_4          = 2'h0;
	localparam logic [1:0]   CH_CODE_6          = 2'h1;
	localparam logic [1:0]   CH_CODE_8          = 2'h2;

	// ---------------------------------------------------------------------------
	// timing defaults
	// ---------------------------------------------------------------------------
	localparam int           MOD_DIV_DEFAULT    = 2;
	localparam int           DECIM_BASE_DEFAULT = 64;
	localparam int           RATE_CODE_MAX      = 6;
	localparam int           TEST_LOG2_DEFAULT  = 21;
	localparam int           TEST_FAST_SHIFT    = 1;

	// ---------------------------------------------------------------------------
	// register layouts
	// ---------------------------------------------------------------------------
	typedef struct packed {
		logic [2:0] silicon_revision;
		logic       always_one;
		logic [1:0] family_code;
		logic [1:0] channel_count_code;
	} adccfg_identity_t;

	typedef struct packed {
		logic       rsv_top;
		logic       multi_readback;
		logic       clk_out_en;
		logic [1:0] rsv_mid;
		logic [2:0] output_rate_code;
	} adccfg_rate_clock_t;

	typedef struct packed {
		logic [2:0] rsv_top;
		logic       internal_source;
		logic       rsv_mid;
		logic       test_amplitude_select;
		logic [1:0] test_frequency_select;
	} adccfg_test_cfg_t;

	typedef struct packed {
		logic       refbuf_on;
		logic [1:0] rsv_mid;
		logic       bias_measure;
		logic       biasref_internal;
		logic       bias_buf_on;
		logic       bias_sense_en;
		logic       bias_lead_off;
	} adccfg_ref_bias_t;

	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic mosi;
	} adccfg_spi_pins_t;

	typedef struct packed {
		logic clock_source_pin;
		logic bias_lead_off;
	} adccfg_misc_pins_t;

	localparam adccfg_rate_clock_t RATE_CLOCK_RESET = 8'h96;
	localparam adccfg_test_cfg_t   TEST_CFG_RESET   = 8'hc0;
	localparam adccfg_ref_bias_t   REF_BIAS_RESET   = 8'h60;
	localparam adccfg_spi_pins_t   SPI_PINS_IDLE    = 3'h4;
	localparam adccfg_misc_pins_t  MISC_PINS_IDLE   = 2'h0;

	typedef struct packed {
		adccfg_rate_clock_t rate_clock;
		adccfg_test_cfg_t   test_cfg;
		adccfg_ref_bias_t   ref_bias;
		logic [7:0]         shift_in;
		logic [7:0]         shift_out;
		logic [7:0]         cmd;
		logic [4:0]         bit_cnt;
		logic               sclk_d;
		logic               osc;
		logic               wave;
		logic               wave_out;
	} adccfg_core_state_t;

	localparam adccfg_core_state_t CORE_STATE_RESET = '{
		rate_clock: RATE_CLOCK_RESET,
		test_cfg:   TEST_CFG_RESET,
		ref_bias:   REF_BIAS_RESET,
		default:    '0
	};

endpackage

// *** logic/adccfg_leaves.sv ***
// two-flop synchroniser and programmable tick divider
`timescale 1ns/1ns
`default_nettype none

module adccfg_sync2 #(
	parameter int           W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         core_clk_in,
	input  wire logic         rstn_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} adccfg_sync_state_t;

	adccfg_sync_state_t st_reg;
	adccfg_sync_state_t st_next;

	// first stage feeds only the second stage
	always_comb begin
		st_next.s1 = d_in;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			st_reg <= '{s1: RST, s2: RST};
		end else begin
			st_reg <= st_next;
		end
	end

	assign q_out = st_reg.s2;
endmodule

module adccfg_tick_div #(
	parameter int W = 14
) (
	input  wire logic         core_clk_in,
	input  wire logic         rstn_in,
	input  wire logic [W-1:0] period_in,
	output logic              tick_out
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} adccfg_tick_state_t;

	adccfg_tick_state_t st_reg;
	adccfg_tick_state_t st_next;

	// compare with >= so that a shortened period wraps at once instead of running to overflow
	assign tick_out = (st_reg.cnt >= (period_in - W'(1)));

	always_comb begin
		st_next.cnt = tick_out ? '0 : st_reg.cnt + W'(1);
	end

	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
endmodule

`default_nettype wire

// *** logic/adccfg_core.sv ***
// identity and global configuration registers behind the serial port
`timescale 1ns/1ns
`default_nettype none

module adccfg_core
	import adccfg_pkg::*;
#(
	parameter int         CHANNELS    = 8,
	parameter logic [2:0] SILICON_REV = 3'h2,   // arbitrary value
	parameter logic [1:0] FAMILY_CODE = 2'h1,   // arbitrary value
	parameter int         MOD_DIV     = MOD_DIV_DEFAULT,
	parameter int         DECIM_BASE  = DECIM_BASE_DEFAULT,
	parameter int         RATE_W      = 14,
	parameter int         TEST_LOG2   = TEST_LOG2_DEFAULT
) (
	input  wire logic             core_clk_in,
	input  wire logic             rstn_in,
	input  wire logic             spi_cs_n_in,
	input  wire logic             spi_sclk_in,
	input  wire logic             spi_mosi_in,
	output logic                  spi_miso_out,
	output logic                  spi_miso_oe_out,
	input  wire logic             clock_source_pin_in,
	input  wire logic             bias_lead_off_in,
	output logic                  clk_pin_out,
	output logic                  clk_pin_oe_out,
	output logic                  multi_readback_out,
	output logic                  data_ready_out,
	output logic                  test_internal_out,
	output logic                  test_double_amp_out,
	output logic                  test_wave_out,
	output adccfg_ref_bias_t      ref_bias_out
);

	// ---------------------------------------------------------------------------
	// elaboration checks
	// ---------------------------------------------------------------------------
	localparam int RATE_BASE = MOD_DIV * DECIM_BASE;

	generate
		if (!(CHANNELS == 4 || CHANNELS == 6 || CHANNELS == 8)) begin : g_bad_ch
			$error("channel count must be 4, 6 or 8");
		end
		if (MOD_DIV < 1 || DECIM_BASE < 1 || (RATE_BASE << RATE_CODE_MAX) > (2 ** RATE_W)) begin : g_bad_rate
			$error("rate divider does not fit its counter");
		end
		if (TEST_LOG2 < 3) begin : g_bad_test
			$error("test divider too short");
		end
	endgenerate

	localparam logic [1:0] CH_CODE = (CHANNELS == 4) ? CH_CODE_4 : (CHANNELS == 6) ? CH_CODE_6 : CH_CODE_8;

	localparam logic [TEST_LOG2-1:0] TEST_HALF_SLOW = {1'b1, {(TEST_LOG2-1){1'b0}}};
	localparam logic [TEST_LOG2-1:0] TEST_HALF_FAST = TEST_HALF_SLOW >> TEST_FAST_SHIFT;

	// ---------------------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------------------
	adccfg_spi_pins_t   spi_raw;
	adccfg_spi_pins_t   spi_s;
	adccfg_misc_pins_t  misc_raw;
	adccfg_misc_pins_t  misc_s;

	assign spi_raw  = '{cs_n: spi_cs_n_in, sclk: spi_sclk_in, mosi: spi_mosi_in};
	assign misc_raw = '{clock_source_pin: clock_source_pin_in, bias_lead_off: bias_lead_off_in};

	adccfg_sync2 #(
		.W   (3),
		.RST (SPI_PINS_IDLE)
	) u_spi_sync (
		.core_clk_in (core_clk_in),
		.rstn_in     (rstn_in),
		.d_in        (spi_raw),
		.q_out       (spi_s)
	);

	adccfg_sync2 #(
		.W   (2),
		.RST (MISC_PINS_IDLE)
	) u_misc_sync (
		.core_clk_in (core_clk_in),
		.rstn_in     (rstn_in),
		.d_in        (misc_raw),
		.q_out       (misc_s)
	);

	// ---------------------------------------------------------------------------
	// state and dividers
	// ---------------------------------------------------------------------------
	adccfg_core_state_t     st_reg;
	adccfg_core_state_t     st_next;
	adccfg_identity_t       identity_word;
	logic [2:0]             rate_code_eff;
	logic [RATE_W-1:0]      rate_period;
	logic [TEST_LOG2-1:0]   test_half;
	logic                   test_tick;
	logic                   sclk_rise;
	logic                   sclk_fall;
	logic [7:0]             rx_byte;
	logic                   cmd_done;
	logic                   write_done;
	logic [7:0]             read_data;

	assign identity_word = '{
		silicon_revision:   SILICON_REV,    // R1
		always_one:         1'b1,           // R1
		family_code:        FAMILY_CODE,    // R2
		channel_count_code: CH_CODE         // R3
	};

	// a reserved code falls back to the slowest rate so the divider never overflows
	assign rate_code_eff = (st_reg.rate_clock.output_rate_code == RATE_CODE_RESERVED) ?
		RATE_CODE_SLOWEST : st_reg.rate_clock.output_rate_code; // R7
	assign rate_period = RATE_W'(RATE_BASE) << rate_code_eff; // R6

	assign test_half = (st_reg.test_cfg.test_frequency_select == TEST_FREQ_FAST) ?
		TEST_HALF_FAST : TEST_HALF_SLOW; // R10

	adccfg_tick_div #(
		.W (RATE_W)
	) u_rate_div (
		.core_clk_in (core_clk_in),
		.rstn_in     (rstn_in),
		.period_in   (rate_period),
		.tick_out    (data_ready_out)
	);

	adccfg_tick_div #(
		.W (TEST_LOG2)
	) u_test_div (
		.core_clk_in (core_clk_in),
		.rstn_in     (rstn_in),
		.period_in   (test_half),
		.tick_out    (test_tick)
	);

	// ---------------------------------------------------------------------------
	// serial decode
	// ---------------------------------------------------------------------------
	// edges are seen on the synchronised pins, so each sclk phase needs at least four core cycles
	assign sclk_rise  = spi_s.sclk & ~st_reg.sclk_d;
	assign sclk_fall  = ~spi_s.sclk & st_reg.sclk_d;
	assign rx_byte    = {st_reg.shift_in[6:0], spi_s.mosi};
	assign cmd_done   = !spi_s.cs_n && sclk_rise && (st_reg.bit_cnt == BITCNT_CMD_LAST);
	assign write_done = !spi_s.cs_n && sclk_rise && (st_reg.bit_cnt == BITCNT_DATA_LAST) && st_reg.cmd[DATA_W-1];

	// identity is read-only: it appears here and nowhere in the write path
	always_comb begin
		case (rx_byte[ADDR_W-1:0])
			ADDR_IDENTITY:   read_data = identity_word; // R1
			ADDR_RATE_CLOCK: read_data = st_reg.rate_clock;
			ADDR_TEST:       read_data = st_reg.test_cfg;
			ADDR_REF_BIAS:   read_data = {st_reg.ref_bias[7:1], misc_s.bias_lead_off}; // R13
			default:         read_data = READ_UNMAPPED;
		endcase
	end

	// a frame cut short by cs_n clears the bit count and writes nothing
	// reserved bits are stored as written; the host keeps them at their reset values
	always_comb begin
		st_next        = st_reg;
		st_next.sclk_d = spi_s.sclk;
		st_next.osc    = ~st_reg.osc;
		if (spi_s.cs_n) begin
			st_next.bit_cnt   = '0;
			st_next.shift_out = '0;
		end else if (sclk_rise && st_reg.bit_cnt != BITCNT_FRAME) begin
			st_next.shift_in = rx_byte;
			st_next.bit_cnt  = st_reg.bit_cnt + 5'h01;
			if (cmd_done) begin
				st_next.cmd = rx_byte;
				if (!rx_byte[DATA_W-1]) begin
					st_next.shift_out = read_data;
				end
			end
			if (write_done) begin
				case (st_reg.cmd[ADDR_W-1:0])
					ADDR_RATE_CLOCK: st_next.rate_clock = rx_byte;              // R4
					ADDR_TEST:       st_next.test_cfg   = rx_byte;              // R8
					ADDR_REF_BIAS:   st_next.ref_bias   = {rx_byte[7:1], 1'b0}; // R13
					default:         st_next.cmd        = st_reg.cmd;
				endcase
			end
		end else if (sclk_fall && st_reg.bit_cnt > BITCNT_SHIFT_FIRST && st_reg.bit_cnt != BITCNT_FRAME) begin
			st_next.shift_out = {st_reg.shift_out[6:0], 1'b0};
		end
		// test waveform: square wave from the divider, dc level, or idle low
		if (test_tick) begin
			st_next.wave = ~st_reg.wave;
		end
		case (st_reg.test_cfg.test_frequency_select)
			TEST_FREQ_DC:     st_next.wave_out = st_reg.test_cfg.internal_source; // R10
			TEST_FREQ_UNUSED: st_next.wave_out = 1'b0;
			default:          st_next.wave_out = st_reg.test_cfg.internal_source & st_next.wave; // R8
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			st_reg <= CORE_STATE_RESET; // R11 R12 R13
		end else begin
			st_reg <= st_next;
		end
	end

	// ---------------------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------------------
	assign spi_miso_out        = st_reg.shift_out[DATA_W-1];
	assign spi_miso_oe_out     = ~spi_s.cs_n;
	assign clk_pin_out         = st_reg.osc;
	assign clk_pin_oe_out      = st_reg.rate_clock.clk_out_en & misc_s.clock_source_pin; // R5
	assign multi_readback_out  = st_reg.rate_clock.multi_readback;                       // R4
	assign test_internal_out   = st_reg.test_cfg.internal_source;                        // R8
	assign test_double_amp_out = st_reg.test_cfg.test_amplitude_select;                  // R9
	assign test_wave_out       = st_reg.wave_out;
	// bit 0 is live lead-off status and is never stored
	assign ref_bias_out        = {st_reg.ref_bias[7:1], misc_s.bias_lead_off};

	// ---------------------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------------------
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rstn_in);

	// spacing is judged only between two pulses of an unchanged period
	logic [RATE_W-1:0] gap_cnt;
	logic [RATE_W-1:0] last_period;
	logic              gap_primed;
	logic              gap_dirty;

	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			gap_cnt     <= '0;
			last_period <= '0;
			gap_primed  <= 1'b0;
			gap_dirty   <= 1'b0;
		end else begin
			last_period <= rate_period;
			gap_cnt     <= data_ready_out ? '0 : gap_cnt + RATE_W'(1);
			if (data_ready_out) begin
				gap_primed <= 1'b1;
				gap_dirty  <= (rate_period != last_period);
			end else if (rate_period != last_period) begin
				gap_dirty <= 1'b1;
			end
		end
	end

	sequence seq_read_id;
		cmd_done && !rx_byte[DATA_W-1] && rx_byte[ADDR_W-1:0] == ADDR_IDENTITY;
	endsequence

	sequence seq_write(logic [6:0] a);
		write_done && st_reg.cmd[ADDR_W-1:0] == a;
	endsequence

	sequence seq_read(logic [6:0] a);
		cmd_done && !rx_byte[DATA_W-1] && rx_byte[ADDR_W-1:0] == a;
	endsequence

	AST_ID_REV_ONE: assert property (seq_read_id |=> st_reg.shift_out[7:4] == {SILICON_REV, 1'b1}) // R1
		else $error("identity revision or fixed one wrong");
	AST_ID_FAMILY: assert property (seq_read_id |=> st_reg.shift_out[3:2] == FAMILY_CODE) // R2
		else $error("identity family code wrong");
	AST_ID_CHANNELS: assert property (seq_read_id |=> st_reg.shift_out[1:0] == CH_CODE) // R3
		else $error("identity channel count wrong");
	AST_READBACK_MODE: assert property (seq_write(ADDR_RATE_CLOCK) |=> multi_readback_out == $past(rx_byte[6])) // R4
		else $error("readback mode not taken from write");
	AST_CLK_OUT_GATE: assert property (clk_pin_oe_out |-> st_reg.rate_clock.clk_out_en && misc_s.clock_source_pin) // R5
		else $error("clock pin driven without enable and select");
	AST_CLK_OUT_ON: assert property (seq_write(ADDR_RATE_CLOCK) // R5
		|=> clk_pin_oe_out == ($past(rx_byte[5]) && misc_s.clock_source_pin))
		else $error("clock pin enable not taken from write");
	AST_RATE_GAP: assert property (data_ready_out && gap_primed && !gap_dirty && rate_period == last_period
		|-> gap_cnt == rate_period - RATE_W'(1)) // R6
		else $error("data ready spacing wrong");
	AST_TEST_SOURCE: assert property (seq_write(ADDR_TEST) |=> test_internal_out == $past(rx_byte[4])) // R8
		else $error("test source not taken from write");
	AST_TEST_AMP: assert property (!(write_done && st_reg.cmd[ADDR_W-1:0] == ADDR_TEST) // R9
		|=> $stable(test_double_amp_out))
		else $error("amplitude changed without write");
	AST_TEST_DC: assert property ((test_internal_out && st_reg.test_cfg.test_frequency_select == TEST_FREQ_DC) // R10
		[*2] |-> test_wave_out)
		else $error("dc test level missing");
	AST_RESET_RATE: assert property ($past(!rstn_in) |-> st_reg.rate_clock == RATE_CLOCK_RESET) // R11
		else $error("rate and clock reset value wrong");
	AST_RESET_TEST: assert property ($past(!rstn_in) |-> st_reg.test_cfg == TEST_CFG_RESET) // R12
		else $error("test reset value wrong");
	AST_RESET_REF: assert property ($past(!rstn_in) |-> st_reg.ref_bias == REF_BIAS_RESET) // R13
		else $error("reference reset value wrong");

	// read path and test waveform
	AST_READ_RATE: assert property (seq_read(ADDR_RATE_CLOCK) |=> st_reg.shift_out == $past(st_reg.rate_clock)) // R11
		else $error("rate and clock register not loaded for read");
	AST_WAVE_EXTERNAL: assert property (!test_internal_out |=> !test_wave_out) // R8
		else $error("test wave driven with external source");
	AST_WAVE_UNUSED: assert property (st_reg.test_cfg.test_frequency_select == TEST_FREQ_UNUSED // R10
		|=> !test_wave_out)
		else $error("test wave driven on unused code");
	AST_MISO_IDLE: assert property (spi_s.cs_n |=> !spi_miso_out)
		else $error("miso not cleared while deselected");

endmodule

`default_nettype wire

// *** logic/adccfg_core_end.sv ***
// spare design file: it holds no module of its own
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// *** tb/adccfg_host.sv ***
// serial-port host model that frames register reads and writes
`timescale 1ns/1ns
`default_nettype none

module adccfg_host
	import adccfg_pkg::*;
(
	input  wire logic core_clk_in,
	output logic      spi_cs_n_out,
	output logic      spi_sclk_out,
	output logic      spi_mosi_out,
	input  wire logic spi_miso_in
);
	initial begin
		spi_cs_n_out = 1'b1;
		spi_sclk_out = 1'b0;
		spi_mosi_out = 1'b0;
	end

	// ------------------------------------------------------------
	// one frame: command byte then data byte, msb first
	// ------------------------------------------------------------
	// sclk phases of five core cycles keep above the four-cycle minimum
	task automatic xfer(input logic [7:0] cmd, input logic [7:0] wdata, output logic [7:0] rdata);
		logic [15:0] frame;
		logic [7:0]  d;
		d = wdata;
		if (cmd[7] && cmd[6:0] == ADDR_RATE_CLOCK && d[2:0] == RATE_CODE_RESERVED) begin
			d[2:0] = RATE_CODE_SLOWEST;
		end
		if (cmd[7]) begin
			case (cmd[6:0])
				ADDR_RATE_CLOCK: d = (d & 8'h67) | 8'h90;
				ADDR_TEST:       d = (d & 8'h17) | 8'hc0;
				ADDR_REF_BIAS:   d = (d & 8'h9f) | 8'h60;
				default:         d = d;
			endcase
		end
		frame = {cmd, d};
		rdata = 8'h00;
		@(posedge core_clk_in);
		spi_cs_n_out <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			spi_sclk_out <= 1'b0;
			spi_mosi_out <= frame[i];
			repeat (4) @(posedge core_clk_in);
			// sample a settled miso half a cycle before raising sclk
			@(negedge core_clk_in);
			rdata = {rdata[6:0], spi_miso_in};
			@(posedge core_clk_in);
			spi_sclk_out <= 1'b1;
			repeat (5) @(posedge core_clk_in);
		end
		spi_sclk_out <= 1'b0;
		// a released data line must not keep showing its last bit
		spi_mosi_out <= ~frame[0];
		repeat (5) @(posedge core_clk_in);
		spi_cs_n_out <= 1'b1;
		repeat (5) @(posedge core_clk_in);
	endtask
endmodule

`default_nettype wire

// *** tb/adc_config_id_registers_test.sv ***
// self-checking bench of the identity and global configuration registers
`timescale 1ns/1ns
`default_nettype none

module adc_config_id_registers_test
	import adccfg_pkg::*;
;
	localparam logic [2:0] TB_REV    = 3'h5; // arbitrary value
	localparam logic [1:0] TB_FAMILY = 2'h2; // arbitrary value
	localparam int         TB_DECIM  = 4;
	localparam int         TB_TLOG2  = 6;

	logic             clk = 1'b0;
	logic             rstn = 1'b0;
	logic             clk_src = 1'b0;
	logic             bias_lo = 1'b0;
	wire logic        cs_n;
	wire logic        sclk;
	wire logic        mosi;
	logic             miso;
	logic             miso_oe;
	logic             clk_pin;
	logic             clk_pin_oe;
	logic             multi;
	logic             drdy;
	logic             t_int;
	logic             t_amp;
	logic             t_wave;
	adccfg_ref_bias_t ref_bias;
	int               failures = 0;
	int               compares = 0;
	int               cycles = 0;
	logic [31:0]      n;

	always #4 clk = ~clk;

	adccfg_core #(.CHANNELS(8), .SILICON_REV(TB_REV), .FAMILY_CODE(TB_FAMILY), .DECIM_BASE(TB_DECIM),
		.TEST_LOG2(TB_TLOG2)) uut (.core_clk_in(clk), .rstn_in(rstn), .spi_cs_n_in(cs_n),
		.spi_sclk_in(sclk), .spi_mosi_in(mosi), .spi_miso_out(miso), .spi_miso_oe_out(miso_oe),
		.clock_source_pin_in(clk_src), .bias_lead_off_in(bias_lo), .clk_pin_out(clk_pin),
		.clk_pin_oe_out(clk_pin_oe), .multi_readback_out(multi), .data_ready_out(drdy),
		.test_internal_out(t_int), .test_double_amp_out(t_amp), .test_wave_out(t_wave),
		.ref_bias_out(ref_bias));

	adccfg_host host (.core_clk_in(clk), .spi_cs_n_out(cs_n), .spi_sclk_out(sclk), .spi_mosi_out(mosi),
		.spi_miso_in(miso));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic conclude;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		chk_byte({7'h00, got}, {7'h00, exp});
	endtask

	task automatic chk_cnt(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		logic [7:0] unused;
		host.xfer({1'b1, a}, v, unused);
	endtask

	task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
		logic [7:0] v;
		host.xfer({1'b0, a}, 8'h00, v);
		chk_byte(v, exp);
	endtask

	// cycles between two events: data-ready pulses, or edges of the test wave
	task automatic gap(input bit wave, output logic [31:0] cnt);
		logic prev;
		logic hit;
		bit   started;
		cnt = 32'h0;
		started = 1'b0;
		prev = t_wave;
		for (int k = 0; k < 4096; k++) begin
			@(negedge clk);
			hit = wave ? (t_wave !== prev) : (drdy === 1'b1);
			prev = t_wave;
			if (started) begin
				cnt++;
			end
			if (hit && started) begin
				break;
			end
			if (hit) begin
				started = 1'b1;
			end
		end
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic test_reset;
		chk_bit(multi, 1'b0);
		chk_bit(clk_pin_oe, 1'b0);
		chk_bit(miso_oe, 1'b0);
		chk_bit(t_int, 1'b0);
		chk_bit(t_amp, 1'b0);
		chk_byte(ref_bias, 8'h60);
		rd_chk(ADDR_RATE_CLOCK, 8'h96);
		rd_chk(ADDR_TEST, 8'hc0);
		rd_chk(ADDR_REF_BIAS, 8'h60);
	endtask

	task automatic test_identity;
		rd_chk(ADDR_IDENTITY, {TB_REV, 1'b1, TB_FAMILY, CH_CODE_8});
		wr(ADDR_IDENTITY, 8'h00);
		rd_chk(ADDR_IDENTITY, {TB_REV, 1'b1, TB_FAMILY, CH_CODE_8});
		wr(7'h20, 8'h5a);
		rd_chk(7'h20, READ_UNMAPPED);
		rd_chk(ADDR_RATE_CLOCK, 8'h96);
	endtask

	task automatic test_rate_clock;
		logic b;
		wr(ADDR_RATE_CLOCK, 8'hf6);
		chk_bit(multi, 1'b1);
		chk_bit(clk_pin_oe, 1'b0);
		@(posedge clk);
		clk_src <= 1'b1;
		repeat (6) @(posedge clk);
		chk_bit(clk_pin_oe, 1'b1);
		@(negedge clk);
		b = clk_pin;
		@(negedge clk);
		chk_bit(clk_pin ^ b, 1'b1);
		rd_chk(ADDR_RATE_CLOCK, 8'hf6);
		wr(ADDR_RATE_CLOCK, 8'h96);
		chk_bit(clk_pin_oe, 1'b0);
		chk_bit(multi, 1'b0);
		@(posedge clk);
		clk_src <= 1'b0;
	endtask

	task automatic test_rate;
		for (int c = 0; c < 7; c++) begin
			wr(ADDR_RATE_CLOCK, {5'h12, c[2:0]});
			gap(1'b0, n);
			chk_cnt(n, 32'(2 * TB_DECIM) << c);
		end
		wr(ADDR_RATE_CLOCK, 8'h97);
		rd_chk(ADDR_RATE_CLOCK, 8'h96);
	endtask

	task automatic test_signal;
		for (int f = 0; f < 4; f++) begin
			wr(ADDR_TEST, 8'hd4 | 8'(f));
			chk_bit(t_int, 1'b1);
			chk_bit(t_amp, 1'b1);
			if (f < 2) begin
				gap(1'b1, n);
				chk_cnt(n, 32'h1 << (TB_TLOG2 - 1 - f));
			end else begin
				chk_bit(t_wave, f == 3);
			end
		end
		wr(ADDR_TEST, 8'hc3);
		chk_bit(t_int, 1'b0);
		chk_bit(t_amp, 1'b0);
		chk_bit(t_wave, 1'b0);
		wr(ADDR_TEST, 8'hc0);
		rd_chk(ADDR_TEST, 8'hc0);
	endtask

	task automatic test_ref_bias;
		@(posedge clk);
		bias_lo <= 1'b1;
		wr(ADDR_REF_BIAS, 8'h9e);
		rd_chk(ADDR_REF_BIAS, 8'hff);
		chk_byte(ref_bias, 8'hff);
		@(posedge clk);
		bias_lo <= 1'b0;
		wr(ADDR_REF_BIAS, 8'h01);
		rd_chk(ADDR_REF_BIAS, 8'h60);
		chk_byte(ref_bias, 8'h60);
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			failures++;
			conclude();
		end
	end

	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		test_reset();
		test_identity();
		test_rate_clock();
		test_rate();
		test_signal();
		test_ref_bias();
		conclude();
	end
endmodule

`default_nettype wire
